/* File: rtl/pio_pkg.sv */
package pio_pkg;
  // Register word indices
  localparam logic [2:0]  IDX_PORT_DATA   = 3'h0;
  localparam logic [2:0]  IDX_LINE_DIR    = 3'h1;
  localparam logic [2:0]  IDX_IRQ_ENABLE  = 3'h2;
  localparam logic [2:0]  IDX_EDGE_LATCH  = 3'h3;
  localparam logic [2:0]  IDX_OUT_SETTER  = 3'h4;
  localparam logic [2:0]  IDX_OUT_CLEARER = 3'h5;
  // Register geometry
  localparam int          REG_WIDTH       = 32;
  localparam int          ADDR_WIDTH      = 3;
  localparam int          SYNC_STAGES     = 2;
  // Values after reset
  localparam logic [31:0] RST_OUT_LEVEL   = 32'h0000_0000;
  localparam logic [31:0] RST_DIRECTION   = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_ENABLE  = 32'h0000_0000;
  localparam logic [31:0] RST_EDGE_LATCH  = 32'h0000_0000;
  localparam logic [31:0] RST_READ_DATA   = 32'h0000_0000;
endpackage

/* File: rtl/pio_edge_sync.sv */
`timescale 1ns/10ps
module pio_edge_sync
  import pio_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  pin_sense_if.source           sense
);
  // ==========================================================
  // Two-stage synchroniser, then edge compare
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] prev_q;

  // First stage is read only by the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q  <= '0;
      level_q <= '0;
      prev_q  <= '0;
    end else begin
      meta_q  <= pin_in;
      level_q <= meta_q;
      prev_q  <= level_q;
    end
  end

  // Both rising and falling edges count
  assign sense.level    = level_q;
  assign sense.edge_hit = level_q ^ prev_q;

  a_sync_latency: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_03
    $past(arst_n, 2) |-> (level_q == $past(pin_in, 2)))
    else $error("synchronised level not two cycles behind pin");
endmodule

/* File: rtl/pio_led_port.sv */
// Function
// RULE_01 - Every register is a 32-bit word
// RULE_02 - Data write sets driven output levels
// RULE_03 - Data read returns current input pin levels
// RULE_04 - Direction bit one means output line
// RULE_05 - Enable bits gate lines onto interrupt
// RULE_06 - Edge latch records edges, readable and writable
// RULE_07 - Setter write raises selected output bits
// RULE_08 - Clearer write lowers selected output bits
// RULE_09 - Lamps are active low for software
// RULE_10 - Latched edges stick; interrupt while enabled
`timescale 1ns/10ps
module pio_led_port
  import pio_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic [ADDR_WIDTH-1:0] reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [REG_WIDTH-1:0]  reg_wdata,
  output logic      [REG_WIDTH-1:0]  reg_rdata,
  input  wire logic [WIDTH-1:0]      pio_in,
  output logic      [WIDTH-1:0]      pio_out,
  output logic      [WIDTH-1:0]      pio_oe,
  output logic                       irq
);
  // ==========================================================
  // Registers
  logic [WIDTH-1:0]     out_q,  out_d;
  logic [WIDTH-1:0]     dir_q;
  logic [WIDTH-1:0]     ien_q;
  logic [WIDTH-1:0]     edge_q, edge_d;
  logic [REG_WIDTH-1:0] rdata_q, rdata_d;
  logic [WIDTH-1:0]     pin_level;
  logic [WIDTH-1:0]     edge_hit;

  // ==========================================================
  // Pin input synchroniser and edge detect
  pin_sense_if #(.WIDTH(WIDTH)) u_sense ();

  pio_edge_sync #(.WIDTH(WIDTH)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_in   (pio_in),
    .sense    (u_sense)
  );

  // Pins are asynchronous, so only synchronised levels reach logic
  assign pin_level = u_sense.level;
  assign edge_hit  = u_sense.edge_hit;

  // ==========================================================
  // Address decode
  wire wr_data = reg_wr && (reg_addr == IDX_PORT_DATA);
  wire wr_dir  = reg_wr && (reg_addr == IDX_LINE_DIR);
  wire wr_ien  = reg_wr && (reg_addr == IDX_IRQ_ENABLE);
  wire wr_edge = reg_wr && (reg_addr == IDX_EDGE_LATCH);
  wire wr_set  = reg_wr && (reg_addr == IDX_OUT_SETTER);
  wire wr_clr  = reg_wr && (reg_addr == IDX_OUT_CLEARER);
  // Upper word bits are ignored; narrow ports read zero there
  wire [WIDTH-1:0] wbits = reg_wdata[WIDTH-1:0];
  wire out_wr  = wr_data || wr_set || wr_clr;
  wire rd_dir  = reg_rd && (reg_addr == IDX_LINE_DIR);
  wire rd_ien  = reg_rd && (reg_addr == IDX_IRQ_ENABLE);
  wire rd_edge = reg_rd && (reg_addr == IDX_EDGE_LATCH);
  wire wr_none = reg_wr && (reg_addr > IDX_OUT_CLEARER);

  function automatic logic [REG_WIDTH-1:0] widen(input logic [WIDTH-1:0] v);
    widen = '0;
    widen[WIDTH-1:0] = v;
  endfunction

  // ==========================================================
  // Output level update; only one strobe can hit per cycle
  always_comb begin
    out_d = out_q;
    if (wr_data) begin
      out_d = wbits; // RULE_02
    end else if (wr_set) begin
      out_d = out_q | wbits; // RULE_07
    end else if (wr_clr) begin
      out_d = out_q & ~wbits; // RULE_08
    end
  end

  // Write of ones clears; a new edge in the same cycle wins
  always_comb begin
    edge_d = edge_q;
    if (wr_edge) begin
      edge_d = edge_q & ~wbits; // RULE_06
    end
    edge_d = edge_d | edge_hit; // RULE_10
  end

  // Read mux; unmapped and write-only words read zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (reg_addr == IDX_PORT_DATA) begin
        rdata_d = widen(pin_level); // RULE_03
      end else if (reg_addr == IDX_LINE_DIR) begin
        rdata_d = widen(dir_q); // RULE_04
      end else if (reg_addr == IDX_IRQ_ENABLE) begin
        rdata_d = widen(ien_q); // RULE_05
      end else if (reg_addr == IDX_EDGE_LATCH) begin
        rdata_d = widen(edge_q); // RULE_06
      end else begin
        rdata_d = RST_READ_DATA; // RULE_01
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_q   <= RST_OUT_LEVEL[WIDTH-1:0];
      dir_q   <= RST_DIRECTION[WIDTH-1:0];
      ien_q   <= RST_IRQ_ENABLE[WIDTH-1:0];
      edge_q  <= RST_EDGE_LATCH[WIDTH-1:0];
      rdata_q <= RST_READ_DATA;
    end else begin
      out_q   <= out_d;
      edge_q  <= edge_d;
      rdata_q <= rdata_d;
      if (wr_dir) begin
        dir_q <= wbits; // RULE_04
      end
      if (wr_ien) begin
        ien_q <= wbits; // RULE_05
      end
    end
  end

  // ==========================================================
  // Outputs; lamps light on a low level, software inverts
  assign pio_out   = out_q; // RULE_09
  assign pio_oe    = dir_q; // RULE_04
  assign irq       = |(edge_q & ien_q); // RULE_10
  assign reg_rdata = rdata_q;

  // ==========================================================
  // Checks
  a_data_write: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_02
    wr_data |=> (pio_out == $past(wbits)))
    else $error("data write not driven on outputs");

  a_set_strobe: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_07
    wr_set |=> (pio_out == ($past(out_q) | $past(wbits))))
    else $error("setter write wrong result");

  a_clear_strobe: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_08
    wr_clr |=> (pio_out == ($past(out_q) & ~$past(wbits))))
    else $error("clearer write wrong result");

  a_dir_enable: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_04
    wr_dir |=> (pio_oe == $past(wbits)))
    else $error("direction write not on output enables");

  a_read_pins: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_03
    (reg_rd && reg_addr == IDX_PORT_DATA) |=> (reg_rdata == widen($past(pin_level))))
    else $error("data read does not show pin levels");

  a_edge_sticky: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_10
    (edge_q != '0 && !wr_edge) |=> ((edge_q & $past(edge_q)) == $past(edge_q)))
    else $error("latched edge lost without a write");

  a_edge_catch: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_06
    (edge_hit != '0) |=> ((edge_q & $past(edge_hit)) == $past(edge_hit)))
    else $error("edge not latched");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_05
    (wr_ien && (wbits & edge_d) != '0) |=> irq)
    else $error("enabled latched edge gives no interrupt");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_01
    (reg_rd && reg_addr > IDX_EDGE_LATCH) |=> (reg_rdata == 32'h0000_0000))
    else $error("write-only or unmapped word read nonzero");

  // Hold checks catch a stray enable on the output, direction and read-data registers
  a_edge_clear: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_06
    (wr_edge && edge_hit == '0) |=> (edge_q == ($past(edge_q) & ~$past(wbits))))
    else $error("edge latch write-one-to-clear wrong");

  a_ien_write: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_05
    wr_ien |=> (ien_q == $past(wbits)))
    else $error("enable write not stored");

  a_irq_masked: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_05
    (wr_ien && wbits == '0) |=> !irq)
    else $error("interrupt with all enables off");

  a_irq_rise: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_10
    ((edge_hit & ien_q) != '0 && !wr_ien) |=> irq)
    else $error("enabled new edge gives no interrupt");

  a_irq_sticky: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_10
    (irq && !wr_edge && !wr_ien) |=> irq)
    else $error("interrupt dropped without a write");

  a_out_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_02
    !out_wr |=> $stable(pio_out))
    else $error("outputs moved without a write");

  a_dir_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_04
    !wr_dir |=> $stable(pio_oe))
    else $error("direction moved without a write");

  a_rdata_hold: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_01
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  a_read_dir: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_04
    rd_dir |=> (reg_rdata == widen($past(dir_q))))
    else $error("direction read wrong");

  a_read_ien: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_05
    rd_ien |=> (reg_rdata == widen($past(ien_q))))
    else $error("enable read wrong");

  a_read_edge: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_06
    rd_edge |=> (reg_rdata == widen($past(edge_q))))
    else $error("edge latch read wrong");

  a_unmapped_write: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_01
    wr_none |=> ($stable(pio_out) && $stable(pio_oe) && $stable(ien_q)))
    else $error("write to unmapped word changed state");
endmodule

/* File: rtl/README_none.sv */
`timescale 1ns/10ps
interface pin_sense_if #(
  parameter int WIDTH = 2
);
  // Synchronised pin levels and their one-cycle change marks
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] edge_hit;

  modport source (output level, output edge_hit);
  modport sink   (input  level, input  edge_hit);
endinterface

/* File: tb/lamp_pair.sv */
`timescale 1ns/10ps
module lamp_pair (
  input  wire logic [1:0] pio_out,
  input  wire logic [1:0] pio_oe,
  input  wire logic [1:0] ext,
  output logic      [1:0] pin,
  output logic      [1:0] lit
);
  // Input lines take the level the bench applies
  assign pin = (pio_oe & pio_out) | (~pio_oe & ext);
  assign lit = ~pin;
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import pio_pkg::*;
  logic        core_clk  = 1'b0;
  logic        arst_n    = 1'b0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [2:0]  reg_addr  = 3'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] x;
  logic [1:0]  ext       = 2'h0;
  logic [1:0]  pio_out, pio_oe, pin, lit;
  logic        irq;
  int          n_fail, tests_run, cyc, out_m, d, k;
  int          exp_q [$];
  logic [2:0]  ops [3]   = '{3'h0, 3'h4, 3'h5};
  // ==========
  // Harness
  always #5 core_clk = ~core_clk;
  pio_led_port #(.WIDTH(2)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pio_in(pin), .pio_out(pio_out), .pio_oe(pio_oe), .irq(irq));
  lamp_pair u_lamp (.pio_out(pio_out), .pio_oe(pio_oe), .ext(ext), .pin(pin), .lit(lit));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    x = reg_rdata;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ==========
  // Stimulus
  initial begin
    d = $urandom(32'hc42b49a1);
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    chk({pio_oe, pio_out, lit}, 32'h3);
    chk(irq, 1'b0);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk(x, 32'h0);
    end
    // Lamps follow the register only once their lines are outputs
    wr(IDX_LINE_DIR, 32'h3);
    wr(IDX_PORT_DATA, 32'h3);
    chk(lit, 32'h0);
    wr(IDX_PORT_DATA, 32'h0);
    chk(lit, 32'h3);
    wr(3'h7, 32'h3);
    chk(pio_out, 32'h0);
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      k = $urandom_range(0, 2);
      wr(ops[k], d);
      out_m = (k == 0) ? (d & 3) : (k == 1) ? (out_m | d & 3) : (out_m & ~d & 3);
      chk(pio_out, out_m);
      chk(lit, ~out_m & 3);
    end
    d = $urandom;
    k = $urandom;
    wr(IDX_LINE_DIR, d);
    wr(IDX_IRQ_ENABLE, k);
    exp_q.push_back(d & 3);
    exp_q.push_back(k & 3);
    rd(IDX_LINE_DIR);
    chk(x, exp_q.pop_front());
    chk(pio_oe, d & 3);
    rd(IDX_IRQ_ENABLE);
    chk(x, exp_q.pop_front());
    wr(IDX_LINE_DIR, 32'h0);
    wr(IDX_PORT_DATA, 32'h0);
    wr(IDX_IRQ_ENABLE, 32'h1);
    rd(IDX_IRQ_ENABLE);
    chk(x, 32'h1);
    // Output phase left edges latched; clear them before fresh ones
    wr(IDX_EDGE_LATCH, 32'h3);
    rd(IDX_EDGE_LATCH);
    chk(x, 32'h0);
    chk(irq, 1'b0);
    @(posedge core_clk);
    ext <= 2'h3;
    repeat (4) @(posedge core_clk);
    rd(IDX_EDGE_LATCH);
    chk(x, 32'h3);
    chk(irq, 1'b1);
    rd(IDX_PORT_DATA);
    chk(x, 32'h3);
    wr(IDX_EDGE_LATCH, 32'h1);
    chk(irq, 1'b0);
    wr(IDX_IRQ_ENABLE, 32'h2);
    chk(irq, 1'b1);
    wr(IDX_EDGE_LATCH, 32'h2);
    chk(irq, 1'b0);
    @(posedge core_clk);
    ext <= 2'h0;
    repeat (4) @(posedge core_clk);
    rd(IDX_EDGE_LATCH);
    chk(x, 32'h3);
    end_of_test();
  end
endmodule
